// ### pcc_regs.vh
// register offsets, field positions and reset values for the primary cache control block
// included by the tag store and control design files of the block, not by the hit logic; no processes here
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// register addresses (internal register space)
`define PCC_STATUS_ADDR     32'h0000_00f4
`define PCC_CONTROL_ADDR    32'h0000_00f8
`define PCC_ERR_ADDR_ADDR   32'h0000_00f2
`define PCC_TAG_BASE        32'h0180_0000
`define PCC_TAG_LAST        32'h0180_1fe0

// status fields
`define PCC_ST_PTE_ERR      10
`define PCC_ST_PTE_WR       9
`define PCC_ST_CMD_HI       8
`define PCC_ST_CMD_LO       4
`define PCC_ST_LEFT         3
`define PCC_ST_RIGHT        2
`define PCC_ST_DPAR         1
`define PCC_ST_LOCK         0

// control fields
`define PCC_CT_REDUND       9
`define PCC_CT_POWER_OFF    8
`define PCC_CT_PERF_HI      7
`define PCC_CT_PERF_LO      5
`define PCC_CT_PAR_EN       4
`define PCC_CT_BANK_SEL     3
`define PCC_CT_FORCE_HIT    2
`define PCC_CT_I_EN         1
`define PCC_CT_D_EN         0

// tag entry fields
`define PCC_TG_TAG_HI       31
`define PCC_TG_TAG_LO       12
`define PCC_TG_PARITY       5
`define PCC_TG_VALID_HI     4
`define PCC_TG_VALID_LO     1
`define PCC_TG_ALLOCATED    0

// tag address decode: bit 4 picks the bank, bits 12:5 the index
`define PCC_TG_BANK_BIT     4
`define PCC_TG_IDX_LO       5

// reset values
`define PCC_STATUS_RST      11'h000
`define PCC_CONTROL_RST     9'h000

`endif

// ### pcc_tag_store.v
// tag array of the primary cache, two banks, one read and one write port
// assumes the caller resolves the bank before the access; reads take one cycle
`timescale 1ns/100ps
`include "pcc_regs.vh"

module pcc_tag_store #(
  parameter IDX_W = 8
) (
  // clock
  input  wire             clk,
  // write port
  input  wire             wr_en,
  input  wire             wr_bank,
  input  wire [IDX_W-1:0] wr_idx,
  input  wire [25:0]      wr_data,
  // read port
  input  wire             rd_bank,
  input  wire [IDX_W-1:0] rd_idx,
  output reg  [25:0]      rd_data
);

  // entry is {tag[19:0], parity, valid[3:0], allocation}
  reg [25:0] mem [0:(2<<IDX_W)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[{wr_bank, wr_idx}] <= wr_data;
    end
    rd_data <= mem[{rd_bank, rd_idx}];
  end

endmodule

// ### pcc_hit_ctrl.v
// hit and command qualification of the primary cache from the control bits
// assumes lookup results arrive in the same cycle as the command
`timescale 1ns/100ps

module pcc_hit_ctrl (
  // control bits
  input  wire       i_stream_en,
  input  wire       d_stream_en,
  input  wire       force_hit,
  input  wire       bank_sel,
  input  wire       power_off,
  // access
  input  wire       acc_valid,
  input  wire       acc_istream,
  input  wire       acc_fill,
  input  wire       acc_invalidate,
  input  wire       lookup_hit,
  input  wire       lookup_bank,
  input  wire       access_violation,
  input  wire       translation_not_valid,
  input  wire       modify_clear,
  // results
  output reg        hit,
  output reg        hit_bank,
  output reg        fill_allowed,
  output reg        invalidate_allowed
);

  reg stream_on;
  reg fault;

  always @* begin
    stream_on          = acc_istream ? i_stream_en : d_stream_en;
    fault              = access_violation | translation_not_valid | modify_clear;
    hit                = 1'b0;
    hit_bank           = lookup_bank;
    fill_allowed       = 1'b0;
    invalidate_allowed = acc_valid & acc_invalidate & (i_stream_en | d_stream_en)
                         & ~power_off;
    if (acc_valid & ~acc_invalidate) begin
      if (acc_fill) begin
        fill_allowed = stream_on & ~power_off;
      end else if (stream_on && force_hit) begin
        // forced hit keeps its selected bank even when a fault also forces a hit
        hit      = 1'b1;
        hit_bank = bank_sel;
      end else if (!acc_istream && fault) begin
        hit = 1'b1;
      end else begin
        hit = stream_on & lookup_hit & ~power_off;
      end
    end
  end

endmodule

// ### pcc_ctrl.v
// primary cache control, parity status capture and tag diagnostic access
// assumes one register access per cycle; read data valid the cycle after the request
// the tag array is not reset; software writes every entry before enabling a stream
`timescale 1ns/100ps
`include "pcc_regs.vh"

module pcc_ctrl #(
  parameter IDX_W = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rstn,
  // internal register access
  input  wire             reg_rd,
  input  wire             reg_wr,
  input  wire [31:0]      reg_addr,
  input  wire [31:0]      reg_wdata,
  output reg  [31:0]      reg_rdata,
  output reg              reg_rvalid,
  // memory pipeline events
  input  wire             pte_hard_error,
  input  wire             pte_from_write_miss,
  input  wire             tag_par_left,
  input  wire             tag_par_right,
  input  wire             data_par_err,
  input  wire [4:0]       s6_command,
  input  wire [31:0]      s6_phys_addr,
  // strap
  input  wire             redundancy_active,
  // cache access from the pipeline
  input  wire             acc_valid,
  input  wire             acc_istream,
  input  wire             acc_fill,
  input  wire             acc_invalidate,
  input  wire             lookup_hit,
  input  wire             lookup_bank,
  input  wire             access_violation,
  input  wire             translation_not_valid,
  input  wire             modify_clear,
  // cache results and control
  output wire             cache_hit,
  output wire             cache_hit_bank,
  output wire             cache_fill_allowed,
  output wire             cache_invalidate_allowed,
  output wire             parity_check_enable,
  output wire             power_off_cache,
  output wire [2:0]       perf_monitor_select
);

  // status state
  reg        page_entry_hard_error;
  reg        page_entry_write_error;
  reg [4:0]  err_command;
  reg        left_tag_err;
  reg        right_tag_err;
  reg        data_parity_error_flag;
  reg        capture_lock;
  reg [31:0] cache_error_address;

  // control state
  reg        ctl_power_off;
  reg [2:0]  ctl_perf_sel;
  reg        ctl_par_en;
  reg        ctl_bank_sel;
  reg        ctl_force_hit;
  reg        ctl_i_en;
  reg        ctl_d_en;

  // register decode
  wire sel_status = (reg_addr == `PCC_STATUS_ADDR);
  wire sel_ctl    = (reg_addr == `PCC_CONTROL_ADDR);
  wire sel_eaddr  = (reg_addr == `PCC_ERR_ADDR_ADDR);
  wire tag_span   = (reg_addr >= `PCC_TAG_BASE) && (reg_addr <= `PCC_TAG_LAST);
  wire tag_align  = (reg_addr[3:0] == 4'h0);
  wire sel_tag    = tag_span & tag_align;
  wire wr_status  = reg_wr & sel_status;
  wire wr_ctl     = reg_wr & sel_ctl;
  wire wr_tag     = reg_wr & sel_tag;

  // parity errors count only while checking is on
  wire par_left  = tag_par_left  & ctl_par_en;
  wire par_right = tag_par_right & ctl_par_en;
  wire par_data  = data_par_err  & ctl_par_en;
  wire par_event = par_left | par_right | par_data;
  wire capture   = par_event & ~capture_lock;

  // write-one clears of the page entry flags and the capture lock
  wire clr_pe_hard  = wr_status & reg_wdata[`PCC_ST_PTE_ERR];
  wire clr_pe_write = wr_status & reg_wdata[`PCC_ST_PTE_WR];
  wire clr_lock     = wr_status & reg_wdata[`PCC_ST_LOCK];

  // next status values; hardware set wins over a write-one clear
  reg        next_pe_hard;
  reg        next_pe_write;
  reg [4:0]  next_cmd;
  reg        next_left;
  reg        next_right;
  reg        next_dpar;
  reg        next_lock;
  reg [31:0] next_eaddr;

  always @* begin
    next_pe_hard  = page_entry_hard_error;
    next_pe_write = page_entry_write_error;
    if (pte_hard_error) begin
      next_pe_hard = 1'b1;
    end else if (clr_pe_hard) begin
      next_pe_hard = 1'b0;
    end
    if (pte_hard_error && pte_from_write_miss) begin
      next_pe_write = 1'b1;
    end else if (clr_pe_write) begin
      next_pe_write = 1'b0;
    end
  end

  // error fields frozen while locked
  always @* begin
    next_cmd   = err_command;
    next_left  = left_tag_err;
    next_right = right_tag_err;
    next_dpar  = data_parity_error_flag;
    next_lock  = capture_lock;
    next_eaddr = cache_error_address;
    if (capture) begin
      next_cmd   = s6_command;
      next_left  = par_left;
      next_right = par_right;
      next_dpar  = par_data;
      next_eaddr = {s6_phys_addr[31:3], 3'b000};
      next_lock  = 1'b1;
    end else if (par_event && capture_lock) begin
      next_lock = 1'b1;
    end else if (clr_lock) begin
      next_lock = 1'b0;
    end
  end

  // status register
  always @(posedge clk) begin
    if (!rstn) begin
      {page_entry_hard_error, page_entry_write_error, err_command,
       left_tag_err, right_tag_err, data_parity_error_flag,
       capture_lock} <= `PCC_STATUS_RST;
      cache_error_address <= 32'h0000_0000;
    end else begin
      page_entry_hard_error  <= next_pe_hard;
      page_entry_write_error <= next_pe_write;
      err_command            <= next_cmd;
      left_tag_err           <= next_left;
      right_tag_err          <= next_right;
      data_parity_error_flag <= next_dpar;
      capture_lock           <= next_lock;
      cache_error_address    <= next_eaddr;
    end
  end

  // next control value; a write replaces every writable bit
  reg [8:0] next_ctl;

  always @* begin
    next_ctl = {ctl_power_off, ctl_perf_sel, ctl_par_en, ctl_bank_sel, ctl_force_hit, ctl_i_en,
                ctl_d_en};
    if (wr_ctl) begin
      next_ctl = reg_wdata[`PCC_CT_POWER_OFF:`PCC_CT_D_EN];
    end
  end

  // control register
  always @(posedge clk) begin
    if (!rstn) begin
      {ctl_power_off, ctl_perf_sel, ctl_par_en, ctl_bank_sel, ctl_force_hit, ctl_i_en, ctl_d_en}
        <= `PCC_CONTROL_RST;
    end else begin
      ctl_power_off <= next_ctl[`PCC_CT_POWER_OFF];
      ctl_perf_sel  <= next_ctl[`PCC_CT_PERF_HI:`PCC_CT_PERF_LO];
      ctl_par_en    <= next_ctl[`PCC_CT_PAR_EN];
      ctl_bank_sel  <= next_ctl[`PCC_CT_BANK_SEL];
      ctl_force_hit <= next_ctl[`PCC_CT_FORCE_HIT];
      ctl_i_en      <= next_ctl[`PCC_CT_I_EN];
      ctl_d_en      <= next_ctl[`PCC_CT_D_EN];
    end
  end

  assign parity_check_enable = ctl_par_en;
  assign power_off_cache     = ctl_power_off;
  assign perf_monitor_select = ctl_perf_sel;

  // tag array diagnostic port
  wire [IDX_W-1:0] tag_idx  = reg_addr[`PCC_TG_IDX_LO+IDX_W-1:`PCC_TG_IDX_LO];
  wire             tag_bank = reg_addr[`PCC_TG_BANK_BIT];
  wire [25:0]      tag_wdata = {reg_wdata[`PCC_TG_TAG_HI:`PCC_TG_TAG_LO],
                                reg_wdata[`PCC_TG_PARITY:`PCC_TG_ALLOCATED]};
  wire [25:0]      tag_rdata;

  // powered-off array is not written; reads return stale data
  wire             tag_wr_en = wr_tag & ~ctl_power_off;
  pcc_tag_store #(
    .IDX_W (IDX_W)
  ) u_tags (
    .clk     (clk),
    .wr_en   (tag_wr_en),
    .wr_bank (tag_bank),
    .wr_idx  (tag_idx),
    .wr_data (tag_wdata),
    .rd_bank (tag_bank),
    .rd_idx  (tag_idx),
    .rd_data (tag_rdata)
  );

  pcc_hit_ctrl u_hit (
    .i_stream_en           (ctl_i_en),
    .d_stream_en           (ctl_d_en),
    .force_hit             (ctl_force_hit),
    .bank_sel              (ctl_bank_sel),
    .power_off             (ctl_power_off),
    .acc_valid             (acc_valid),
    .acc_istream           (acc_istream),
    .acc_fill              (acc_fill),
    .acc_invalidate        (acc_invalidate),
    .lookup_hit            (lookup_hit),
    .lookup_bank           (lookup_bank),
    .access_violation      (access_violation),
    .translation_not_valid (translation_not_valid),
    .modify_clear          (modify_clear),
    .hit                   (cache_hit),
    .hit_bank              (cache_hit_bank),
    .fill_allowed          (cache_fill_allowed),
    .invalidate_allowed    (cache_invalidate_allowed)
  );

  // register images as software reads them
  wire [31:0] status_word  = {21'h0, page_entry_hard_error, page_entry_write_error, err_command,
                              left_tag_err, right_tag_err, data_parity_error_flag,
                              capture_lock};
  wire [31:0] control_word = {22'h0, redundancy_active, ctl_power_off, ctl_perf_sel,
                              ctl_par_en, ctl_bank_sel, ctl_force_hit, ctl_i_en,
                              ctl_d_en};
  wire [31:0] tag_word     = {tag_rdata[25:6], 6'h00, tag_rdata[5:0]};

  // read path: register reads answered one cycle later
  reg        rd_q;
  reg [1:0]  rd_sel;
  reg [31:0] rd_reg;
  reg [31:0] next_rd_reg;

  always @* begin
    next_rd_reg = 32'h0000_0000;
    if (sel_status) begin
      next_rd_reg = status_word;
    end else if (sel_ctl) begin
      next_rd_reg = control_word;
    end else if (sel_eaddr) begin
      next_rd_reg = cache_error_address;
    end
  end

  // select taken with the request so the answer matches its address
  always @(posedge clk) begin
    if (!rstn) begin
      rd_q   <= 1'b0;
      rd_sel <= 2'b00;
      rd_reg <= 32'h0000_0000;
    end else begin
      rd_q   <= reg_rd;
      rd_sel <= sel_tag ? 2'b01 : 2'b00;
      rd_reg <= next_rd_reg;
    end
  end

  // tag data comes straight from the array flop
  always @* begin
    reg_rvalid = rd_q;
    if (rd_sel == 2'b01) begin
      reg_rdata = tag_word;
    end else begin
      reg_rdata = rd_reg;
    end
  end

endmodule

// ### pcc_ctrl_assertions.sv
// checker of the primary cache control block
// bound to pcc_ctrl; sees its ports only
`timescale 1ns/100ps
module pcc_ctrl_assertions (
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // register access
  input wire        reg_rd,
  input wire        reg_wr,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_rvalid,
  // pipeline access
  input wire        acc_valid,
  input wire        acc_istream,
  input wire        acc_fill,
  input wire        acc_invalidate,
  input wire        access_violation,
  input wire        translation_not_valid,
  input wire        modify_clear,
  // results
  input wire        cache_hit,
  input wire        cache_hit_bank,
  input wire        cache_fill_allowed,
  input wire        parity_check_enable,
  input wire        power_off_cache,
  input wire [2:0]  perf_monitor_select
);
  reg  [8:0] ctl;
  wire       wc  = reg_wr && reg_addr == 32'h0000_00f8;
  wire       flt = access_violation | translation_not_valid | modify_clear;
  wire       da  = acc_valid && !acc_istream && !acc_invalidate;
  wire       ia  = acc_valid && acc_istream && !acc_invalidate;
  wire       fh  = (da || ia) && !acc_fill && ctl[2] && (acc_istream ? ctl[1] : ctl[0]);
  // shadow of the control register
  always @(posedge clk) begin
    if (!rstn)
      ctl <= 9'h000;
    else if (wc)
      ctl <= reg_wdata[8:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req; reg_rd ##1 !reg_rd; endsequence
  sequence s_ans; reg_rvalid ##1 !reg_rvalid; endsequence
  a_read_answer_pulse: assert property (s_req |-> s_ans)
    else $error("read answer not a single pulse");
  a_par_en_follow: assert property (wc |=> parity_check_enable == $past(reg_wdata[4]))
    else $error("parity enable wrong");
  a_power_follow: assert property (wc |=> power_off_cache == $past(reg_wdata[8]))
    else $error("power off wrong");
  a_perf_follow: assert property (wc |=> perf_monitor_select == $past(reg_wdata[7:5]))
    else $error("perf select wrong");
  a_d_miss_off: assert property (da && !ctl[0] && !ctl[2] && !flt |-> !cache_hit)
    else $error("data hit while disabled");
  a_i_miss_off: assert property (ia && !ctl[1] && !ctl[2] |-> !cache_hit && !cache_fill_allowed)
    else $error("fetch served while disabled");
  a_forced_bank: assert property (fh |-> cache_hit && cache_hit_bank == ctl[3])
    else $error("forced hit or bank wrong");
  a_fault_hit: assert property (da && !acc_fill && flt && !ctl[8] |-> cache_hit)
    else $error("fault did not force hit");
endmodule

// ### pcc_pipe_model.sv
// memory pipeline event source for the cache control block
// bench asks for one event at a time with go
`timescale 1ns/100ps
module pcc_pipe_model (
  // request
  input  wire        clk,
  input  wire        go,
  input  wire [4:0]  kind,
  input  wire [4:0]  cmd,
  input  wire [31:0] addr,
  // events
  output reg         pte_hard_error = 1'b0,
  output reg         pte_from_write_miss = 1'b0,
  output reg         tag_par_left = 1'b0,
  output reg         tag_par_right = 1'b0,
  output reg         data_par_err = 1'b0,
  output reg  [4:0]  s6_command = 5'h00,
  output reg  [31:0] s6_phys_addr = 32'h0
);
  always @(posedge clk) begin
    pte_hard_error      <= go & kind[4];
    pte_from_write_miss <= go & kind[3];
    tag_par_left        <= go & kind[2];
    tag_par_right       <= go & kind[1];
    data_par_err        <= go & kind[0];
    // not held outside an event
    s6_command          <= go ? cmd : ~s6_command;
    s6_phys_addr        <= go ? addr : ~s6_phys_addr;
  end
endmodule

// ### pcc_ctrl_tb_top.sv
// self-checking bench of the primary cache control block
// needs pcc_ctrl, pcc_pipe_model and the checker
`timescale 1ns/100ps
module pcc_ctrl_tb_top;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         reg_rd = 1'b0;
  reg         reg_wr = 1'b0;
  reg  [31:0] reg_addr = 32'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         redundancy_active = 1'b0;
  reg  [8:0]  acc = 9'h000;
  reg         go = 1'b0;
  reg  [4:0]  kind = 5'h00;
  reg  [4:0]  cmd = 5'h00;
  reg  [31:0] addr = 32'h0;
  reg  [31:0] d;
  wire [31:0] reg_rdata;
  wire        reg_rvalid;
  wire        pte_hard_error, pte_from_write_miss, tag_par_left, tag_par_right, data_par_err;
  wire [4:0]  s6_command;
  wire [31:0] s6_phys_addr;
  wire        inv, pce, poff;
  wire [2:0]  pms;
  reg  [8:0]  cm = 9'h000;
  integer     seed = 32'hf9f830ea;
  integer     fail_count = 0;
  integer     total_checks = 0;
  integer     st = 0;
  integer     pa = 0;
  integer     pen = 0;
  integer     k;
  always #5 clk = ~clk;
  always @(posedge clk) acc <= $random(seed);
  // control outputs against the bench's copy of the control register
  always @(negedge clk)
    if (rstn) begin
      chk(inv, acc[0] & acc[3] & (cm[1] | cm[0]) & ~cm[8]);
      chk(pce, cm[4]);
      chk(poff, cm[8]);
      chk(pms, cm[7:5]);
    end
  pcc_pipe_model pcc_pipe_model_inst (.clk, .go, .kind, .cmd, .addr, .pte_hard_error,
    .pte_from_write_miss, .tag_par_left, .tag_par_right, .data_par_err, .s6_command,
    .s6_phys_addr);
  pcc_ctrl #(.IDX_W(8)) pcc_ctrl_inst (.clk, .rstn, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .pte_hard_error, .pte_from_write_miss, .tag_par_left,
    .tag_par_right, .data_par_err, .s6_command, .s6_phys_addr, .redundancy_active,
    .acc_valid(acc[0]), .acc_istream(acc[1]), .acc_fill(acc[2]), .acc_invalidate(acc[3]),
    .lookup_hit(acc[4]), .lookup_bank(acc[5]), .access_violation(acc[6]),
    .translation_not_valid(acc[7]), .modify_clear(acc[8]), .cache_hit(), .cache_hit_bank(),
    .cache_fill_allowed(), .cache_invalidate_allowed(inv), .parity_check_enable(pce),
    .power_off_cache(poff), .perf_monitor_select(pms));
  task chk(input [31:0] s, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task give_verdict;
    begin
      if (fail_count == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (a == 32'hf8)
        cm = v[8:0];
    end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid, 32'h1);
      chk(reg_rdata, e);
    end
  endtask
  // kind: pte, write miss, left, right, data
  task fire(input [4:0] kd, input [4:0] c, input [31:0] a);
    begin
      @(posedge clk);
      go <= 1'b1;
      kind <= kd;
      cmd <= c;
      addr <= a;
      @(posedge clk);
      go <= 1'b0;
      if (kd[4])
        st = st | (kd[3] ? 32'h600 : 32'h400);
      else if (pen != 0 && st[0] == 1'b0) begin
        st = (st & 32'h600) | (c << 4) | (kd[2:0] << 1) | 1;
        pa = a & ~32'h7;
      end
      @(posedge clk);
    end
  endtask
  initial begin
    #900000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(32'hf4, 0);
    rd(32'hf8, 0);
    rd(32'h0, 0);
    for (k = 0; k < 12; k = k + 1) begin
      d = $random(seed);
      if (d[1:0] != 2'b00)
        d[8] = 1'b0;
      @(posedge clk);
      redundancy_active <= d[9];
      wr(32'hf8, d);
      repeat (6) @(posedge clk);
      rd(32'hf8, d & 32'h3ff);
    end
    wr(32'hf8, 32'h10);
    pen = 1;
    for (k = 0; k < 3; k = k + 1) begin
      d = $random(seed);
      fire(5'h4 >> k, d[4:0], d);
      rd(32'hf4, st);
      rd(32'hf2, pa);
      fire(5'h7, ~d[4:0], ~d);
      rd(32'hf4, st);
      rd(32'hf2, pa);
      wr(32'hf4, 32'h1fe);
      rd(32'hf4, st);
      wr(32'hf4, 32'h1);
      st = st & ~1;
      rd(32'hf4, st);
    end
    wr(32'hf8, 32'h8);
    pen = 0;
    fire(5'h1, 5'h1f, 32'hffff_fff8);
    rd(32'hf4, st);
    fire(5'h18, 5'h0, 32'h0);
    rd(32'hf4, st);
    wr(32'hf4, 32'h600);
    st = st & ~32'h600;
    rd(32'hf4, st);
    fire(5'h10, 5'h0, 32'h0);
    rd(32'hf4, st);
    d = $random(seed);
    for (k = 0; k < 3; k = k + 1)
      wr(32'h0180_1fc0 + 16 * k, d + k);
    for (k = 0; k < 3; k = k + 1)
      rd(32'h0180_1fc0 + 16 * k, (d + k) & 32'hffff_f03f);
    give_verdict;
  end
endmodule
bind pcc_ctrl pcc_ctrl_assertions pcc_ctrl_assertions_inst (.clk, .rstn, .reg_rd, .reg_wr,
  .reg_addr, .reg_wdata, .reg_rvalid, .acc_valid, .acc_istream, .acc_fill, .acc_invalidate,
  .access_violation, .translation_not_valid, .modify_clear, .cache_hit, .cache_hit_bank,
  .cache_fill_allowed, .parity_check_enable, .power_off_cache, .perf_monitor_select);
